/* File: six_pin_io_pkg.sv */
// Shared constants and types for the six-pin I/O port.
package six_pin_io_pkg;

	// Bus and port widths.
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int REG_W  = 8;
	localparam int PORT_W = 6;

	// Register indices; the byte address is four times the index.
	localparam logic [5:0] IDX_STATUS   = 6'h03;
	localparam logic [5:0] IDX_DIR_LOAD = 6'h05;
	localparam logic [5:0] IDX_PORT     = 6'h06;
	localparam logic [5:0] IDX_OPTION   = 6'h07;
	localparam logic [5:0] IDX_CONFIG   = 6'h08;
	localparam logic [5:0] IDX_SLEEP    = 6'h09;

	// Field positions.
	localparam int STAT_WAKE_BIT   = 7;
	localparam int OPT_WAKE_EN_BIT = 7;
	localparam int OPT_PULL_EN_BIT = 6;
	localparam int OPT_TMR_SRC_BIT = 5;
	localparam int CFG_OSC_LSB     = 0;
	localparam int CFG_MASTER_CLEAR_INPUT_EN_BIT = 4;

	// Pin positions with alternate functions.
	localparam int PIN_TMR_CLK = 2;
	localparam int PIN_MASTER_CLEAR_INPUT    = 3;
	localparam int PIN_OSC_OUT = 4;
	localparam int PIN_OSC_IN  = 5;

	// Pins sharing pull-up and wake-on-change, and reset values.
	localparam logic [5:0] GROUP_MASK   = 6'h0b;
	localparam logic [5:0] DIR_RESET    = 6'h3f;
	localparam logic [7:0] OPTION_RESET = 8'h00;
	localparam logic [7:0] CONFIG_RESET = 8'h02;

	// Oscillator modes held in the configuration register.
	typedef enum logic [1:0] {
		OSC_LOW_POWER_XTAL = 2'h0,
		OSC_STD_XTAL       = 2'h1,
		OSC_INT_RC         = 2'h2,
		OSC_EXT_RC         = 2'h3
	} osc_mode_t;

	// Four non-overlapping phases of one instruction cycle.
	typedef enum logic [3:0] {
		PHASE_ONE   = 4'h1,
		PHASE_TWO   = 4'h2,
		PHASE_THREE = 4'h4,
		PHASE_FOUR  = 4'h8
	} phase_t;

endpackage

/* File: phase_gen.sv */
// Divide-by-four generator of the four instruction phases.
`timescale 1ns/10ps
`default_nettype none
module phase_gen
	import six_pin_io_pkg::*;
(
	// Clock and reset.
	input  wire logic clk_i,
	input  wire logic reset_n_i,
	// Current phase.
	output var  phase_t phase_o
);

	// Rotate one-hot through the phases; reset restarts at phase one.
	always_ff @(posedge clk_i) begin
		if (!reset_n_i) begin
			phase_o <= PHASE_ONE;
		end else begin
			case (phase_o)
				PHASE_ONE:   phase_o <= PHASE_TWO;
				PHASE_TWO:   phase_o <= PHASE_THREE;
				PHASE_THREE: phase_o <= PHASE_FOUR;
				PHASE_FOUR:  phase_o <= PHASE_ONE;
				default:     phase_o <= PHASE_ONE;
			endcase
		end
	end

endmodule
`default_nettype wire

/* File: pin_sync.sv */
// Two-stage synchroniser for the port pin inputs.
`timescale 1ns/10ps
`default_nettype none
module pin_sync #(
	parameter int WIDTH = 6
) (
	// Clock and reset.
	input  wire logic             clk_i,
	input  wire logic             reset_n_i,
	// Raw and synchronised levels.
	input  wire logic [WIDTH-1:0] async_i,
	output logic      [WIDTH-1:0] sync_o
);

	logic [WIDTH-1:0] meta_r;

	// A zero-width port cannot be served.
	if (WIDTH < 1) begin : g_bad_width
		$error("pin_sync WIDTH must be at least one");
	end

	// The first stage is read by the second stage only.
	always_ff @(posedge clk_i) begin
		if (!reset_n_i) begin
			meta_r <= '0;
			sync_o <= '0;
		end else begin
			meta_r <= async_i;
			sync_o <= meta_r;
		end
	end

endmodule
`default_nettype wire

/* File: six_pin_io_port.sv */
// Six-pin general purpose I/O port with APB register access.
`timescale 1ns/10ps
`default_nettype none
// Overview of operation
// - Clock divided by four into phases; port activity aligned to them.
// - Reads sample in phase two; writes take effect in phase four.
// - Port read returns pin levels, not the output latch.
// - Device reset (reset_n_i) sets all direction bits to one, pins become inputs.
// - Port register is eight bits; top two read as zero.
// - Pin 3 is input only; others individually programmable.
// - Pins taken by alternate functions read as zero.
// - Pins 0, 1, 3 share group-wide pull-up and wake-on-change enables.
// - Master clear on pin 3 forces pull-up, no wake, low resets.
// - Direction loaded only by its dedicated load; never readable.
// - Direction one floats the pin; zero drives the latch.
// - Timer configuration may take pin 2 away from the port.
// - Output latches hold until rewritten; the input snapshot is taken only at port reads.
// - Pin 4 is the crystal output in both crystal modes.
// - Pin 5 is a port pin only in internal RC mode.
// - Wake flag is one after pin-change wake reset, else zero.
// - Timer source select makes the timer count the pin 2 clock.
module six_pin_io_port
	import six_pin_io_pkg::*;
(
	// Clock and resets.
	input  wire logic              clk_i,
	input  wire logic              reset_n_i,
	input  wire logic              por_n_i,
	// APB slave.
	input  wire logic              psel_i,
	input  wire logic              penable_i,
	input  wire logic              pwrite_i,
	input  wire logic [ADDR_W-1:0] paddr_i,
	input  wire logic [DATA_W-1:0] pwdata_i,
	output logic      [DATA_W-1:0] prdata_o,
	output logic                   pready_o,
	output logic                   pslverr_o,
	// Port pins.
	input  wire logic [PORT_W-1:0] pin_in_i,
	output logic      [PORT_W-1:0] pin_out_o,
	output logic      [PORT_W-1:0] pin_oe_n_o,
	output logic      [PORT_W-1:0] pull_up_o,
	// Core side.
	output var  phase_t            phase_o,
	output logic                   timer_clk_o,
	output logic                   timer_src_o,
	output logic                   master_clear_o,
	output logic                   wake_reset_o,
	output logic                   sleeping_o
);

	logic [PORT_W-1:0] pins_s;
	logic [PORT_W-1:0] dir_r;
	logic [PORT_W-1:0] latch_r;
	logic [PORT_W-1:0] last_read_r;
	logic [PORT_W-1:0] alt_mask;
	logic [PORT_W-1:0] drive_en;
	logic [PORT_W-1:0] wake_mask;
	logic [REG_W-1:0]  option_r;
	logic [REG_W-1:0]  config_r;
	logic [REG_W-1:0]  rd_val;
	logic              wake_flag_r;
	logic              wake_pend_r;
	logic              in_reset_r;
	logic              access;
	logic              slot;
	logic              mapped;
	logic              wr_fire;
	logic              rd_port;
	logic              master_clear_input_en;
	logic              tmr_src;
	logic              wake_fire;
	osc_mode_t         osc_mode;

	// Byte address of a register index.
	function automatic logic reg_hit(input logic [ADDR_W-1:0] addr, input logic [5:0] idx);
		reg_hit = (addr == {idx, 2'b00});
	endfunction

	phase_gen u_phase (
		.clk_i     (clk_i),
		.reset_n_i (reset_n_i),
		.phase_o   (phase_o)
	);

	// Pins come from outside the clock domain.
	pin_sync #(.WIDTH(PORT_W)) u_sync (
		.clk_i     (clk_i),
		.reset_n_i (reset_n_i),
		.async_i   (pin_in_i),
		.sync_o    (pins_s)
	);

	// Decoded configuration.
	assign osc_mode = osc_mode_t'(config_r[CFG_OSC_LSB +: 2]);
	assign master_clear_input_en  = config_r[CFG_MASTER_CLEAR_INPUT_EN_BIT];
	assign tmr_src  = option_r[OPT_TMR_SRC_BIT];

	// Pins lent to alternate functions; they neither drive nor read back.
	always_comb begin
		alt_mask = '0;
		alt_mask[PIN_OSC_IN]  = (osc_mode != OSC_INT_RC);
		alt_mask[PIN_OSC_OUT] = (osc_mode == OSC_LOW_POWER_XTAL) || (osc_mode == OSC_STD_XTAL);
		alt_mask[PIN_MASTER_CLEAR_INPUT]    = master_clear_input_en;
		alt_mask[PIN_TMR_CLK] = tmr_src;
	end

	always_comb begin
		drive_en           = ~dir_r & ~alt_mask;
		drive_en[PIN_MASTER_CLEAR_INPUT] = 1'b0;
	end

	// APB decode; each access waits for its phase slot.
	assign access  = psel_i && penable_i && !pready_o;
	assign mapped  = reg_hit(paddr_i, IDX_STATUS) || reg_hit(paddr_i, IDX_DIR_LOAD)
		|| reg_hit(paddr_i, IDX_PORT) || reg_hit(paddr_i, IDX_OPTION)
		|| reg_hit(paddr_i, IDX_CONFIG) || reg_hit(paddr_i, IDX_SLEEP);
	// read in phase two, write in phase four
	assign slot    = pwrite_i ? (phase_o == PHASE_FOUR) : (phase_o == PHASE_TWO);
	assign wr_fire = access && slot && pwrite_i && mapped;
	assign rd_port = access && slot && !pwrite_i && reg_hit(paddr_i, IDX_PORT);

	// Read data mux; the direction register reads as zero.
	always_comb begin
		rd_val = '0;
		if (reg_hit(paddr_i, IDX_STATUS)) begin
			rd_val[STAT_WAKE_BIT] = wake_flag_r;
		end else if (reg_hit(paddr_i, IDX_PORT)) begin
			rd_val = {2'b00, pins_s & ~alt_mask};
		end else if (reg_hit(paddr_i, IDX_OPTION)) begin
			rd_val = option_r;
		end else if (reg_hit(paddr_i, IDX_CONFIG)) begin
			rd_val = config_r;
		end
	end

	// Bus answer; unmapped addresses answer with an error in their slot.
	always_ff @(posedge clk_i) begin
		if (!reset_n_i) begin
			pready_o  <= 1'b0;
			pslverr_o <= 1'b0;
			prdata_o  <= '0;
		end else if (access && slot) begin
			pready_o  <= 1'b1;
			pslverr_o <= !mapped;
			prdata_o  <= pwrite_i ? '0 : {24'h000000, rd_val};
		end else begin
			pready_o  <= 1'b0;
			pslverr_o <= 1'b0;
		end
	end

	// loaded only at its own address
	always_ff @(posedge clk_i) begin
		if (!reset_n_i) begin
			dir_r <= DIR_RESET;
		end else if (wr_fire && reg_hit(paddr_i, IDX_DIR_LOAD)) begin
			dir_r <= pwdata_i[PORT_W-1:0];
		end
	end

	always_ff @(posedge clk_i) begin
		if (wr_fire && reg_hit(paddr_i, IDX_PORT)) begin
			latch_r <= pwdata_i[PORT_W-1:0];
		end
	end

	// Option and configuration; the configuration stands in for fuses.
	always_ff @(posedge clk_i) begin
		if (!reset_n_i) begin
			option_r <= OPTION_RESET;
			config_r <= CONFIG_RESET;
		end else if (wr_fire && reg_hit(paddr_i, IDX_OPTION)) begin
			option_r <= pwdata_i[REG_W-1:0];
		end else if (wr_fire && reg_hit(paddr_i, IDX_CONFIG)) begin
			config_r <= pwdata_i[REG_W-1:0];
		end
	end

	// direction zero drives the latch
	// Undriven outputs show zero, so an unwritten latch reaches no pin while its direction bit is one.
	always_ff @(posedge clk_i) begin
		if (!reset_n_i) begin
			pin_out_o  <= '0;
			pin_oe_n_o <= '1;
		end else begin
			pin_out_o  <= latch_r & drive_en;
			pin_oe_n_o <= ~drive_en;
		end
	end

	always_ff @(posedge clk_i) begin
		if (!reset_n_i) begin
			pull_up_o <= '0;
		end else begin
			pull_up_o <= (option_r[OPT_PULL_EN_BIT] ? GROUP_MASK : 6'h00)
				| (master_clear_input_en ? 6'h08 : 6'h00);
		end
	end

	always_ff @(posedge clk_i) begin
		if (!reset_n_i) begin
			timer_clk_o    <= 1'b0;
			timer_src_o    <= 1'b0;
			master_clear_o <= 1'b0;
		end else begin
			timer_clk_o    <= tmr_src && pins_s[PIN_TMR_CLK];
			timer_src_o    <= tmr_src;
			master_clear_o <= master_clear_input_en && !pins_s[PIN_MASTER_CLEAR_INPUT];
		end
	end

	// inputs captured only at a port read
	// The snapshot is the reference for wake comparison.
	always_ff @(posedge clk_i) begin
		if (!reset_n_i) begin
			last_read_r <= '0;
		end else if (rd_port) begin
			last_read_r <= pins_s;
		end
	end

	// one wake enable for the group
	// master clear pin excluded from wake
	always_comb begin
		wake_mask           = option_r[OPT_WAKE_EN_BIT] ? GROUP_MASK : 6'h00;
		wake_mask[PIN_MASTER_CLEAR_INPUT] = wake_mask[PIN_MASTER_CLEAR_INPUT] && !master_clear_input_en;
	end

	assign wake_fire = sleeping_o && ((pins_s & wake_mask) != (last_read_r & wake_mask));

	// Sleep is entered by writing its address and left by reset or wake.
	always_ff @(posedge clk_i) begin
		if (!reset_n_i) begin
			sleeping_o   <= 1'b0;
			wake_reset_o <= 1'b0;
		end else begin
			wake_reset_o <= wake_fire;
			if (wake_fire) begin
				sleeping_o <= 1'b0;
			end else if (wr_fire && reg_hit(paddr_i, IDX_SLEEP)) begin
				sleeping_o <= 1'b1;
			end
		end
	end

	// wake flag reflects the reset cause
	// The pending mark is copied to the wake flag as the device reset begins, then cleared; the flag survives that reset.
	always_ff @(posedge clk_i) begin
		if (!por_n_i) begin
			wake_pend_r <= 1'b0;
			wake_flag_r <= 1'b0;
			in_reset_r  <= 1'b0;
		end else begin
			in_reset_r <= !reset_n_i;
			if (!reset_n_i) begin
				wake_pend_r <= 1'b0;
				if (!in_reset_r) begin
					wake_flag_r <= wake_pend_r;
				end
			end else if (wake_reset_o) begin
				wake_pend_r <= 1'b1;
			end else if (wr_fire && reg_hit(paddr_i, IDX_STATUS)) begin
				wake_flag_r <= pwdata_i[STAT_WAKE_BIT];
			end
		end
	end

	// Phase rotation as a named sequence.
	sequence s_rotate;
		phase_o == PHASE_TWO ##1 phase_o == PHASE_THREE ##1 phase_o == PHASE_FOUR
			##1 phase_o == PHASE_ONE;
	endsequence

	sequence s_read_done;
		pready_o && psel_i && !pwrite_i && !pslverr_o && reg_hit(paddr_i, IDX_PORT);
	endsequence

	a_phase_rotation: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		phase_o == PHASE_ONE |=> s_rotate)
		else $error("phases did not rotate in order");
	a_write_phase_four: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		pready_o && pwrite_i |-> $past(phase_o) == PHASE_FOUR)
		else $error("write answered outside phase four");
	a_read_pins: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		s_read_done |-> prdata_o[5:0] == ($past(pins_s) & ~$past(alt_mask))
			&& $past(phase_o) == PHASE_TWO)
		else $error("port read did not return pins sampled in phase two");
	a_dir_after_reset: assert property (@(posedge clk_i)
		!reset_n_i |=> dir_r == DIR_RESET)
		else $error("direction not all ones after reset");
	a_upper_bits_zero: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		s_read_done |-> prdata_o[31:6] == '0)
		else $error("unimplemented port bits read nonzero");
	a_pin3_input_only: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		pin_oe_n_o[PIN_MASTER_CLEAR_INPUT])
		else $error("pin 3 output driver enabled");
	a_osc_in_reads_zero: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		s_read_done and (osc_mode != OSC_INT_RC) |-> !prdata_o[PIN_OSC_IN])
		else $error("oscillator pin read nonzero");
	// The wake mask follows the enable in the same cycle; the pull-up is registered.
	a_master_clear_input_pull_no_wake: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		master_clear_input_en |-> !wake_mask[PIN_MASTER_CLEAR_INPUT] ##1 pull_up_o[PIN_MASTER_CLEAR_INPUT])
		else $error("master clear pull-up or wake wrong");
	a_timer_pin_float: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		tmr_src |=> pin_oe_n_o[PIN_TMR_CLK])
		else $error("timer pin still driven");
	a_drive_follows_dir: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		!dir_r[0] && !alt_mask[0] ##1 !dir_r[0] |-> !pin_oe_n_o[0]
			&& pin_out_o[0] == $past(latch_r[0]))
		else $error("pin 0 not driving latch value");
	a_wake_pulse: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		wake_fire |=> wake_reset_o && !sleeping_o)
		else $error("mismatch while asleep gave no wake reset");

endmodule
`default_nettype wire

/* File: pin_partner.sv */
// Model of the external circuitry hanging on the six port pins.
`timescale 1ns/10ps
`default_nettype none
module pin_partner (
	// Clock.
	input  wire logic       clk_i,
	// Levels the far side drives, and where it drives them.
	input  wire logic [5:0] ext_val_i,
	input  wire logic [5:0] ext_en_i,
	// Pin controls from the block.
	input  wire logic [5:0] pin_out_i,
	input  wire logic [5:0] pin_oe_n_i,
	input  wire logic [5:0] pull_up_i,
	// Resolved pin levels.
	output logic      [5:0] pin_o
);
	logic [5:0] float_r = 6'h15;

	// A floating pin with no pull-up wanders every cycle, so a read of it is never trusted.
	always_ff @(posedge clk_i) begin
		float_r <= ~float_r;
	end

	// levels resolved every cycle, nothing held
	// The far side wins a fight, then the block's driver, then the pull-up.
	always_comb begin
		for (int i = 0; i < 6; i++) begin
			if (ext_en_i[i])
				pin_o[i] = ext_val_i[i];
			else if (!pin_oe_n_i[i])
				pin_o[i] = pin_out_i[i];
			else if (pull_up_i[i])
				pin_o[i] = 1'b1;
			else
				pin_o[i] = float_r[i];
		end
	end
endmodule
`default_nettype wire

/* File: six_pin_io_port_test.sv */
// Self-checking testbench for the six-pin I/O port.
`timescale 1ns/10ps
`default_nettype none
module six_pin_io_port_test
	import six_pin_io_pkg::*;
;
	logic        clk_i = 1'b0, reset_n_i, por_n_i, psel_i, penable_i, pwrite_i;
	logic [7:0]  paddr_i;
	logic [31:0] pwdata_i, prdata_o;
	logic        pready_o, pslverr_o, timer_clk_o, timer_src_o;
	logic        master_clear_o, wake_reset_o, sleeping_o;
	logic [5:0]  pin_in_i, pin_out_o, pin_oe_n_o, pull_up_o, ext_val, ext_en;
	phase_t      phase_o;
	int          num_errors = 0;
	int          checks = 0;

	six_pin_io_port six_pin_io_port_i (.clk_i(clk_i), .reset_n_i(reset_n_i), .por_n_i(por_n_i),
		.psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
		.pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
		.pin_in_i(pin_in_i), .pin_out_o(pin_out_o), .pin_oe_n_o(pin_oe_n_o),
		.pull_up_o(pull_up_o), .phase_o(phase_o), .timer_clk_o(timer_clk_o),
		.timer_src_o(timer_src_o), .master_clear_o(master_clear_o),
		.wake_reset_o(wake_reset_o), .sleeping_o(sleeping_o));

	pin_partner pin_partner_i (.clk_i(clk_i), .ext_val_i(ext_val), .ext_en_i(ext_en),
		.pin_out_i(pin_out_o), .pin_oe_n_i(pin_oe_n_o), .pull_up_i(pull_up_o), .pin_o(pin_in_i));

	// Free-running 100 MHz clock.
	initial begin
		forever #5 clk_i = ~clk_i;
	end

	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		checks++;
		if (got !== exp) begin
			num_errors++;
			$display("[ERR] %s expected %h seen %h", name, exp, got);
		end
	endtask

	// One APB transfer; the answer is checked against the phase that follows its slot (phase one for writes, phase three for reads).
	task automatic apb(input logic wr, input logic [5:0] idx, input logic [31:0] wd,
			output logic [31:0] rdata, output logic err);
		int n;
		@(posedge clk_i);
		psel_i <= 1'b1;
		pwrite_i <= wr;
		paddr_i <= {idx, 2'b00};
		pwdata_i <= wd;
		@(posedge clk_i);
		penable_i <= 1'b1;
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (pready_o !== 1'b1 && n < 20);
		chk("pready", 32'h1, {31'h0, pready_o});
		chk("slot", wr ? 32'h1 : 32'h4, {28'h0, phase_o});
		rdata = prdata_o;
		err = pslverr_o;
		psel_i <= 1'b0;
		penable_i <= 1'b0;
	endtask

	task automatic wr(input logic [5:0] idx, input logic [7:0] d);
		logic [31:0] x;
		logic        e;
		apb(1'b1, idx, {24'h0, d}, x, e);
		repeat (2) @(posedge clk_i);
	endtask

	task automatic rd_chk(input string name, input logic [5:0] idx, input logic [31:0] exp,
			input logic [31:0] mask);
		logic [31:0] x;
		logic        e;
		apb(1'b0, idx, 32'h0, x, e);
		chk(name, exp, x & mask);
		chk("pslverr", 32'h0, {31'h0, e});
	endtask

	task automatic pins(input logic [5:0] en, input logic [5:0] v);
		ext_en <= en;
		ext_val <= v;
		repeat (4) @(posedge clk_i);
	endtask

	task automatic t_reset();
		logic [3:0]  p;
		logic [31:0] x;
		logic        e;
		chk("oe_rst", 32'h3f, {26'h0, pin_oe_n_o});
		rd_chk("option", IDX_OPTION, {24'h0, OPTION_RESET}, 32'hffffffff);
		rd_chk("config", IDX_CONFIG, {24'h0, CONFIG_RESET}, 32'hffffffff);
		rd_chk("wake_por", IDX_STATUS, 32'h0, 32'hffffffff);
		rd_chk("dir_rd", IDX_DIR_LOAD, 32'h0, 32'hffffffff);
		apb(1'b0, 6'h10, 32'h0, x, e);
		chk("unmapped", 32'h1, {31'h0, e});
		#1;
		repeat (8) begin
			p = phase_o;
			@(posedge clk_i);
			#1;
			chk("phase", {28'h0, p[2:0], p[3]}, {28'h0, phase_o});
		end
	endtask

	task automatic t_read();
		pins(6'h3f, 6'h2a);
		rd_chk("pins_a", IDX_PORT, 32'h2a, 32'hffffffff);
		pins(6'h3f, 6'h15);
		rd_chk("pins_b", IDX_PORT, 32'h15, 32'hffffffff);
	endtask

	task automatic t_drive();
		pins(6'h00, 6'h00);
		wr(IDX_PORT, 8'h3f);
		wr(IDX_DIR_LOAD, 8'h00);
		chk("oe_n", 32'h08, {26'h0, pin_oe_n_o});
		chk("out", 32'h37, {26'h0, pin_out_o});
		rd_chk("drive", IDX_PORT, 32'h37, 32'h37);
		pins(6'h01, 6'h00);
		rd_chk("fight", IDX_PORT, 32'h36, 32'h37);
		wr(IDX_DIR_LOAD, 8'h3f);
		chk("float", 32'h3f, {26'h0, pin_oe_n_o});
		wr(IDX_DIR_LOAD, 8'h00);
		chk("held", 32'h37, {26'h0, pin_out_o});
	endtask

	task automatic t_alt();
		logic e4;
		logic e5;
		pins(6'h3f, 6'h3f);
		for (int m = 0; m < 4; m++) begin
			wr(IDX_CONFIG, 8'(m));
			e4 = (m >= 2);
			e5 = (m == 2);
			rd_chk("osc_rd", IDX_PORT, {26'h0, e5, e4, 4'hf}, 32'h3f);
			chk("osc_oe", {30'h0, ~e5, ~e4}, {30'h0, pin_oe_n_o[5:4]});
		end
		wr(IDX_CONFIG, 8'h02);
		wr(IDX_OPTION, 8'h20);
		chk("tmr_src", 32'h1, {31'h0, timer_src_o});
		chk("tmr_oe", 32'h1, {31'h0, pin_oe_n_o[2]});
		rd_chk("tmr_rd", IDX_PORT, 32'h3b, 32'h3f);
		pins(6'h3f, 6'h3b);
		chk("tmr_lo", 32'h0, {31'h0, timer_clk_o});
		pins(6'h3f, 6'h3f);
		chk("tmr_hi", 32'h1, {31'h0, timer_clk_o});
		wr(IDX_OPTION, 8'h40);
		chk("pull", 32'h0b, {26'h0, pull_up_o});
		wr(IDX_OPTION, 8'h00);
		wr(IDX_CONFIG, 8'h12);
		pins(6'h37, 6'h3f);
		chk("mc_pull", 32'h1, {31'h0, pull_up_o[3]});
		rd_chk("mc_rd", IDX_PORT, 32'h37, 32'h3f);
		pins(6'h3f, 6'h37);
		chk("mc_low", 32'h1, {31'h0, master_clear_o});
		pins(6'h3f, 6'h3f);
		wr(IDX_CONFIG, 8'h02);
	endtask

	task automatic t_wake();
		int n;
		wr(IDX_OPTION, 8'h80);
		pins(6'h3f, 6'h00);
		rd_chk("snap", IDX_PORT, 32'h0, 32'h3f);
		wr(IDX_SLEEP, 8'h00);
		pins(6'h3f, 6'h04);
		repeat (4) @(posedge clk_i);
		chk("asleep", 32'h1, {31'h0, sleeping_o});
		ext_val <= 6'h06;
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (wake_reset_o !== 1'b1 && n < 20);
		chk("wake", 32'h1, {31'h0, wake_reset_o});
		reset_n_i <= 1'b0;
		repeat (8) @(posedge clk_i);
		reset_n_i <= 1'b1;
		rd_chk("wake_flag", IDX_STATUS, 32'h80, 32'hffffffff);
		wr(IDX_STATUS, 8'h00);
		rd_chk("wake_clr", IDX_STATUS, 32'h0, 32'hffffffff);
	endtask

	task automatic results();
		if (num_errors == 0 && checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// Main sequence, starting with both resets held for eight cycles.
	initial begin
		{reset_n_i, por_n_i, psel_i, penable_i, pwrite_i} = 5'h0;
		paddr_i = 8'h00;
		pwdata_i = 32'h0;
		ext_val = 6'h00;
		ext_en = 6'h00;
		repeat (8) @(posedge clk_i);
		reset_n_i <= 1'b1;
		por_n_i <= 1'b1;
		t_reset();
		t_read();
		t_drive();
		t_alt();
		t_wake();
		results();
	end

	// Watchdog well beyond the few hundred cycles the tests need.
	initial begin
		#500us;
		num_errors++;
		results();
	end
endmodule
`default_nettype wire
